//--- rtl/mmc_map_ctrl.sv
/*
 * Memory map and mode control: mode strap and mode register, page index
 * registers, local-to-global expansion and region select for CPU and debug
 * masters, Avalon-MM register slave.
 * Assumes masters present one request per cycle and the bus master holds
 * a request until it sees waitrequest low.
 */
module mmc_map_ctrl (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_mode_pin,
    input wire logic i_secured,
    input wire logic i_stop,
    input wire logic i_dbg_active,
    input wire logic i_dbg_page_enable,
    input wire logic i_call_page_wr,
    input wire logic [7:0] i_call_page,
    input wire mmc_pkg::mmc_req_s i_cpu_req,
    input wire mmc_pkg::mmc_req_s i_dbg_req,
    output mmc_pkg::mmc_map_s o_cpu_map,
    output mmc_pkg::mmc_map_s o_dbg_map,
    output logic o_illegal_reset,
    output logic o_special_mode
);
    import mmc_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [17:0] expand(input logic [15:0] la, input logic [3:0] pix);
        logic [3:0] page;
        page = pix;
        if (la <= LOCAL_DIRECT_TOP) begin
            return {2'b00, la};
        end
        case (la[15:14])
            2'b00: page = PAGE_LOW;
            2'b01: page = PAGE_MID;
            2'b10: page = pix;
            default: page = PAGE_TOP;
        endcase
        return {page, la[13:0]};
    endfunction

    function automatic logic dbg_hit(input logic [15:0] la, input logic [3:0] pix);
        return (la[15:8] == DBG_HI_BYTE) || (la[15:8] == DBG_WIN_BYTE && pix == DBG_WIN_PAGE);
    endfunction

    function automatic mmc_region_e region(input logic [17:0] ga, input logic ifr_on);
        if (ga <= REG_TOP) begin
            return MMC_RG_REGS;
        end else if (ga >= IFR_LO && ga <= IFR_HI) begin
            return ifr_on ? MMC_RG_IFR : MMC_RG_UNIMPL;
        end else if (ga <= HOLE_HI) begin
            return MMC_RG_UNIMPL;
        end else if (ga < RAM_LO + RAM_SIZE) begin
            return MMC_RG_RAM;
        end else if ({1'b0, ga} >= FLASH_END - {1'b0, FLASH_SIZE} && ga <= FLASH_TOP) begin
            return MMC_RG_FLASH;
        end
        return MMC_RG_UNIMPL;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [3:0] page_reg;
    logic [3:0] dbgpage_reg;
    logic ifr_on_reg;
    logic mode_reg;
    logic lock_reg;
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic pin_s3_reg;
    logic pin_filt_reg;
    logic [1:0] strap_cnt_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    mmc_map_s cpu_map_reg;
    mmc_map_s dbg_map_reg;
    logic illegal_reg;
    logic bus_req;
    logic bus_acc;
    logic [7:0] bus_idx;
    logic bus_wr;
    logic strap_busy;
    logic mode_new;
    logic [3:0] cpu_pix;
    logic [3:0] dbg_pix;
    logic [17:0] cpu_ga;
    logic [17:0] dbg_ga;

    assign bus_req = i_avs_read || i_avs_write;
    assign bus_acc = bus_req && !wait_reg;
    assign bus_idx = i_avs_address[9:2];
    assign bus_wr = bus_acc && i_avs_write && i_avs_byteenable[0];
    assign strap_busy = strap_cnt_reg != 2'h0;
    assign mode_new = i_avs_writedata[MODE_BIT];

    // ----------------------------------------
    // Mode pin synchroniser and strap capture
    // ----------------------------------------
    // No reset here: the strap is tracked while reset is held
    always_ff @(posedge i_clock) begin
        pin_s1_reg <= i_mode_pin;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
    end

    always_ff @(posedge i_clock) begin
        if (pin_s2_reg == pin_s3_reg) begin
            pin_filt_reg <= pin_s3_reg;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_cnt_reg <= STRAP_CYCLES;
        end else if (strap_busy) begin
            strap_cnt_reg <= strap_cnt_reg - 2'h1;
        end
    end

    // ----------------------------------------
    // Mode register and write lock
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg <= MODE_RST;
            lock_reg <= 1'b0;
        end else if (strap_busy) begin
            mode_reg <= pin_filt_reg;
        end else if (bus_wr && bus_idx == IDX_MODE && !lock_reg) begin
            if (i_secured) begin
                mode_reg <= mode_reg;
            end else if (mode_new == mode_reg || !mode_reg) begin
                mode_reg <= mode_new;
            end else begin
                lock_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Page index and map control registers
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_reg <= PAGE_RST;
        end else if (i_call_page_wr && !i_stop) begin
            page_reg <= i_call_page[3:0];
        end else if (bus_wr && bus_idx == IDX_PAGE) begin
            page_reg <= i_avs_writedata[3:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dbgpage_reg <= DBGPAGE_RST;
            ifr_on_reg <= 1'b0;
        end else if (bus_wr && bus_idx == IDX_DBGPAGE) begin
            dbgpage_reg <= i_avs_writedata[3:0];
        end else if (bus_wr && bus_idx == IDX_MAPCTL) begin
            ifr_on_reg <= i_avs_writedata[IFR_BIT];
        end
    end

    // ----------------------------------------
    // Avalon-MM slave
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg <= 1'b1;
        end else if (bus_req && wait_reg && !i_stop) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0;
        end else if (i_avs_read && wait_reg) begin
            if (bus_idx == IDX_PAGE) begin
                rdata_reg <= {24'h0, PAGE_HI_ONES, page_reg};
            end else if (bus_idx == IDX_MODE) begin
                rdata_reg <= {24'h0, mode_reg, 7'h0};
            end else if (bus_idx == IDX_MAPCTL) begin
                rdata_reg <= {31'h0, ifr_on_reg};
            end else if (bus_idx == IDX_DBGPAGE) begin
                rdata_reg <= {28'h0, dbgpage_reg};
            end else begin
                rdata_reg <= 32'h0;
            end
        end
    end

    // ----------------------------------------
    // Address expansion and region select
    // ----------------------------------------
    // Debug page only for enabled firmware or hardware commands
    assign cpu_pix = (i_dbg_page_enable && i_cpu_req.fw_cmd) ? dbgpage_reg : page_reg;
    assign dbg_pix = i_dbg_page_enable ? dbgpage_reg : page_reg;
    assign cpu_ga = expand(i_cpu_req.addr, cpu_pix);
    assign dbg_ga = expand(i_dbg_req.addr, dbg_pix);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_map_reg <= '0;
            illegal_reg <= 1'b0;
        end else if (i_stop) begin
            cpu_map_reg.valid <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            cpu_map_reg.valid <= i_cpu_req.valid;
            cpu_map_reg.gaddr <= cpu_ga;
            illegal_reg <= 1'b0;
            if (i_dbg_active && i_cpu_req.dbg_cycle && dbg_hit(i_cpu_req.addr, cpu_pix)) begin
                cpu_map_reg.region <= MMC_RG_DEBUG;
            end else begin
                cpu_map_reg.region <= region(cpu_ga, ifr_on_reg);
                // Internal memory only; unimplemented CPU access resets unless it is a firmware command
                illegal_reg <= i_cpu_req.valid && !i_cpu_req.fw_cmd
                    && region(cpu_ga, ifr_on_reg) == MMC_RG_UNIMPL;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dbg_map_reg <= '0;
        end else if (i_stop) begin
            dbg_map_reg.valid <= 1'b0;
        end else begin
            dbg_map_reg.valid <= i_dbg_req.valid;
            dbg_map_reg.gaddr <= dbg_ga;
            if (i_dbg_active && i_dbg_req.dbg_cycle && dbg_hit(i_dbg_req.addr, dbg_pix)) begin
                dbg_map_reg.region <= MMC_RG_DEBUG;
            end else begin
                dbg_map_reg.region <= region(dbg_ga, ifr_on_reg);
            end
        end
    end

    assign o_avs_waitrequest = wait_reg;
    assign o_avs_readdata = rdata_reg;
    assign o_cpu_map = cpu_map_reg;
    assign o_dbg_map = dbg_map_reg;
    assign o_illegal_reset = illegal_reg;
    assign o_special_mode = !mode_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_rd_mapctl;
        i_avs_read && wait_reg && bus_idx == IDX_MAPCTL;
    endsequence

    sequence s_cpu_window;
        i_cpu_req.valid && !i_stop && i_cpu_req.addr[15:14] == 2'b10
            && !(i_dbg_active && i_cpu_req.dbg_cycle);
    endsequence

    AST_MODE_STRAP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        strap_busy |=> mode_reg == $past(pin_filt_reg))
        else $error("mode bit did not follow strap");

    AST_MODE_LOCK: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (lock_reg && !strap_busy) |=> mode_reg == $past(mode_reg))
        else $error("locked mode bit changed");

    AST_MODE_NOUP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!strap_busy && mode_reg && bus_wr && bus_idx == IDX_MODE && !mode_new && !i_secured)
        |=> mode_reg && lock_reg)
        else $error("illegal mode change accepted");

    AST_SECURE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_secured && !strap_busy) |=> $stable(mode_reg))
        else $error("mode changed while secured");

    AST_MAPCTL_RD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_rd_mapctl ##1 !o_avs_waitrequest |-> o_avs_readdata == {31'h0, ifr_on_reg})
        else $error("map control read wrong");

    AST_IFR_MAP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_cpu_map.valid && o_cpu_map.gaddr >= IFR_LO && o_cpu_map.gaddr <= IFR_HI)
        |-> o_cpu_map.region == (ifr_on_reg ? MMC_RG_IFR : MMC_RG_UNIMPL))
        else $error("info sector decode wrong");

    AST_DBG_HIDDEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (o_cpu_map.region == MMC_RG_DEBUG && o_cpu_map.valid)
        |-> $past(i_dbg_active) && $past(i_cpu_req.dbg_cycle))
        else $error("debug resource visible outside debug cycle");

    AST_WINDOW: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (s_cpu_window and !i_cpu_req.fw_cmd)
        |=> o_cpu_map.gaddr == {$past(page_reg), $past(i_cpu_req.addr[13:0])})
        else $error("window expansion wrong");

    AST_FIXED_TOP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_cpu_req.valid && !i_stop && i_cpu_req.addr[15:14] == 2'b11)
        |=> o_cpu_map.gaddr[17:14] == PAGE_TOP)
        else $error("top block not fixed");

    AST_ILLEGAL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_illegal_reset |-> o_cpu_map.region == MMC_RG_UNIMPL && !$past(i_cpu_req.fw_cmd))
        else $error("spurious illegal access reset");

    AST_STOP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_stop |=> !o_cpu_map.valid && !o_dbg_map.valid && o_avs_waitrequest)
        else $error("active during stop");

    AST_PAGE_RST: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(strap_busy == 1'b0) && $past(strap_cnt_reg) == 2'h1 && !$past(bus_wr)
        && !$past(i_call_page_wr) |-> page_reg == PAGE_RST)
        else $error("page index not at reset value");
endmodule // mmc_map_ctrl

//--- rtl/mmc_pkg.sv
/*
 * Constants, types and register map of the memory map and mode control unit.
 * Assumes a 10 MHz system bus clock and an 18-bit global address space.
 */
// Contract
// - Mode follows pin in reset, then register bit (code: mode bit reset to 0, tracks filtered pin 3 cycles after release)
// - Pin level captured into mode bit at release
// - Illegal mode write ignored, locks outside special
// - Secured device refuses every mode change
// - Map control: bit 0 visibility, rest zero
// - Visibility bit maps info sector at 0x400-0x47F
// - Normal single-chip: internal fetch, no external access
// - Special single-chip: debug controls CPU, no bus
// - Debug resources visible only in debug cycles
// - Active debug maps debug resources at 0xFF00-0xFFFF
// - Overlapped resources hidden during active debug
// - Debug resources also at 0xBF00 when page 0xFF
// - Page index selects 16 kB block at 0x8000
// - Page index writable by bus and far calls
// - Top 16 kB always maps fixed page
// - Debug reaches page registers, same expansion scheme
// - Debug page used only when enabled, commands
// - Fixed registers, hole and RAM regions
// - Flash ends at 0x3_FFFF, sized downward
// - Memory sizes fixed, not software changeable
// - CPU unimplemented access resets; debug access allowed
// - Page index resets to 0xFE
// - Active in run and wait, idle in stop
package mmc_pkg;
    // ----------------------------------------
    // Register map (index, byte address is 4x)
    // ----------------------------------------
    localparam logic [7:0] IDX_PAGE = 8'h30;
    localparam logic [7:0] IDX_MODE = 8'h32;
    localparam logic [7:0] IDX_MAPCTL = 8'h33;
    localparam logic [7:0] IDX_DBGPAGE = 8'h34;
    localparam int MODE_BIT = 7;
    localparam int IFR_BIT = 0;
    localparam logic [3:0] PAGE_RST = 4'hE;
    localparam logic [3:0] DBGPAGE_RST = 4'hE;
    localparam logic [3:0] PAGE_HI_ONES = 4'hF;
    localparam logic MODE_RST = 1'b0;
    localparam logic [1:0] STRAP_CYCLES = 2'h3;
    // ----------------------------------------
    // Global and local map
    // ----------------------------------------
    localparam logic [17:0] REG_TOP = 18'h003FF;
    localparam logic [17:0] IFR_LO = 18'h00400;
    localparam logic [17:0] IFR_HI = 18'h0047F;
    localparam logic [17:0] HOLE_HI = 18'h007FF;
    localparam logic [17:0] RAM_LO = 18'h00800;
    localparam logic [17:0] RAM_SIZE = 18'h00800;
    localparam logic [17:0] FLASH_SIZE = 18'h08000;
    localparam logic [18:0] FLASH_END = 19'h40000;
    localparam logic [17:0] FLASH_TOP = 18'h3FFFF;
    localparam logic [15:0] LOCAL_DIRECT_TOP = 16'h0FFF;
    localparam logic [3:0] PAGE_LOW = 4'hC;
    localparam logic [3:0] PAGE_MID = 4'hD;
    localparam logic [3:0] PAGE_TOP = 4'hF;
    localparam logic [7:0] DBG_HI_BYTE = 8'hFF;
    localparam logic [7:0] DBG_WIN_BYTE = 8'hBF;
    localparam logic [3:0] DBG_WIN_PAGE = 4'hF;

    typedef enum logic [2:0] {
        MMC_RG_REGS,
        MMC_RG_IFR,
        MMC_RG_RAM,
        MMC_RG_FLASH,
        MMC_RG_DEBUG,
        MMC_RG_UNIMPL
    } mmc_region_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic fw_cmd;
        logic dbg_cycle;
    } mmc_req_s;

    typedef struct packed {
        logic valid;
        logic [17:0] gaddr;
        mmc_region_e region;
    } mmc_map_s;
endpackage

//--- sim/mmc_master_model.sv
/*
 * Request issuer standing for the CPU core or the debug unit on one map port.
 * Assumes one clock and the one-cycle request timing of the map path.
 */
module mmc_master_model (
    input wire logic i_clock,
    output mmc_pkg::mmc_req_s o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    import mmc_pkg::*;
    // ----------------------------------------
    // Request issue
    // ----------------------------------------
    initial begin
        o_req = '0;
    end
    // One request for one cycle after an optional idle gap, then scrambled fields
    task automatic issue(input logic [15:0] a, input logic fw, input logic dc, input int gap);
        repeat (gap) @(posedge i_clock);
        o_req <= '{valid: 1'b1, write: 1'b0, addr: a, fw_cmd: fw, dbg_cycle: dc};
        @(posedge i_clock);
        o_req <= '{valid: 1'b0, write: 1'b1, addr: ~a, fw_cmd: ~fw, dbg_cycle: ~dc};
    endtask
endmodule // mmc_master_model

//--- sim/test_memory_map_mode_control.sv
/*
 * Self-checking bench of the map and mode control unit.
 * Assumes the register slave and map timing of the designer's hand-over.
 */
module test_memory_map_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    import mmc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [9:0] i_avs_address = 10'h000;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [3:0] i_avs_byteenable = 4'h1;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic i_mode_pin = 1'b1;
    logic i_secured = 1'b0;
    logic i_stop = 1'b0;
    logic i_dbg_active = 1'b0;
    logic i_dbg_page_enable = 1'b0;
    logic i_call_page_wr = 1'b0;
    logic [7:0] i_call_page = 8'h00;
    mmc_req_s cpu_req;
    mmc_req_s dbg_req;
    mmc_map_s o_cpu_map;
    mmc_map_s o_dbg_map;
    logic o_illegal_reset;
    logic o_special_mode;
    logic [31:0] rdata;
    logic ifr_on = 1'b0;
    int mismatches = 0;
    int tests_run = 0;

    always #50 i_clock = ~i_clock;

    mmc_master_model u_cpu_master (.i_clock(i_clock), .o_req(cpu_req));
    mmc_master_model u_dbg_master (.i_clock(i_clock), .o_req(dbg_req));
    mmc_map_ctrl u_mmc_map_ctrl (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_mode_pin(i_mode_pin), .i_secured(i_secured),
        .i_stop(i_stop), .i_dbg_active(i_dbg_active), .i_dbg_page_enable(i_dbg_page_enable),
        .i_call_page_wr(i_call_page_wr), .i_call_page(i_call_page), .i_cpu_req(cpu_req),
        .i_dbg_req(dbg_req), .o_cpu_map(o_cpu_map), .o_dbg_map(o_dbg_map),
        .o_illegal_reset(o_illegal_reset), .o_special_mode(o_special_mode)
    );
    // ----------------------------------------
    // Shared tasks and expectations
    // ----------------------------------------
    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic do_reset(input logic pin);
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        i_mode_pin <= pin;
        ifr_on = 1'b0;
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (8) @(posedge i_clock);
    endtask
    // Avalon cycle: hold until waitrequest is sampled low, then release
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        i_avs_address <= {idx, 2'b00};
        i_avs_writedata <= {24'h000000, wd};
        i_avs_byteenable <= be;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (o_avs_waitrequest !== 1'b0) begin
            mismatches++;
            give_verdict();
        end
        @(posedge i_clock);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00, 4'h1, rdata);
        check(what, exp, rdata);
    endtask
    function automatic logic [17:0] expand(input logic [15:0] a, input logic [3:0] pg);
        if (a <= LOCAL_DIRECT_TOP) return {2'b00, a};
        case (a[15:14])
            2'b00: return {PAGE_LOW, a[13:0]};
            2'b01: return {PAGE_MID, a[13:0]};
            2'b10: return {pg, a[13:0]};
            default: return {PAGE_TOP, a[13:0]};
        endcase
    endfunction
    function automatic mmc_region_e region(input logic [17:0] g);
        if (g <= REG_TOP) return MMC_RG_REGS;
        if (g <= IFR_HI) return ifr_on ? MMC_RG_IFR : MMC_RG_UNIMPL;
        if (g <= HOLE_HI) return MMC_RG_UNIMPL;
        if (g <= RAM_LO + RAM_SIZE - 18'h00001) return MMC_RG_RAM;
        if ({1'b0, g} >= FLASH_END - {1'b0, FLASH_SIZE}) return MMC_RG_FLASH;
        return MMC_RG_UNIMPL;
    endfunction
    // One request on one port, outputs judged one cycle later
    task automatic map_chk(input logic dbg, input logic [15:0] a, input logic fw,
                           input logic dc, input logic [3:0] pg, input logic hit,
                           input logic ill);
        mmc_map_s m;
        logic [17:0] g;
        g = expand(a, pg);
        if (dbg) begin
            u_dbg_master.issue(a, fw, dc, 2);
        end else begin
            u_cpu_master.issue(a, fw, dc, 0);
        end
        @(posedge i_clock);
        m = dbg ? o_dbg_map : o_cpu_map;
        check("map valid", 32'h00000001, {31'h0, m.valid});
        check("map gaddr", {14'h0, g}, {14'h0, m.gaddr});
        check("map region", {29'h0, hit ? MMC_RG_DEBUG : region(g)}, {29'h0, m.region});
        check("illegal reset", {31'h0, ill}, {31'h0, o_illegal_reset});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_reset_values();
        rd_chk("page reset", IDX_PAGE, 32'h000000FE);
        rd_chk("map ctl reset", IDX_MAPCTL, 32'h00000000);
        rd_chk("mode strap", IDX_MODE, 32'h00000080);
        check("special flag", 32'h0, {31'h0, o_special_mode});
        rd_chk("unmapped read", 8'h3F, 32'h00000000);
    endtask
    task automatic sc_mode();
        do_reset(1'b0);
        rd_chk("mode strap low", IDX_MODE, 32'h00000000);
        check("special flag low", 32'h1, {31'h0, o_special_mode});
        i_secured <= 1'b1;
        bus(1'b1, IDX_MODE, 8'h80, 4'h1, rdata);
        rd_chk("secured write", IDX_MODE, 32'h00000000);
        i_secured <= 1'b0;
        bus(1'b1, IDX_MODE, 8'h80, 4'h1, rdata);
        rd_chk("special to normal", IDX_MODE, 32'h00000080);
        check("normal flag", 32'h0, {31'h0, o_special_mode});
        bus(1'b1, IDX_MODE, 8'h00, 4'h1, rdata);
        rd_chk("normal to special", IDX_MODE, 32'h00000080);
    endtask
    task automatic sc_mapctl();
        bus(1'b1, IDX_MAPCTL, 8'hFF, 4'h1, rdata);
        ifr_on = 1'b1;
        rd_chk("map ctl bits", IDX_MAPCTL, 32'h00000001);
        map_chk(1'b0, 16'h0410, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
        bus(1'b1, IDX_MAPCTL, 8'h00, 4'h1, rdata);
        ifr_on = 1'b0;
        map_chk(1'b0, 16'h0410, 1'b0, 1'b0, 4'hE, 1'b0, 1'b1);
        map_chk(1'b1, 16'h0500, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
        map_chk(1'b0, 16'h0500, 1'b1, 1'b0, 4'hE, 1'b0, 1'b0);
        map_chk(1'b0, 16'h0100, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
        map_chk(1'b0, 16'h0900, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
    endtask
    task automatic sc_paging();
        for (int p = 0; p < 16; p++) begin
            bus(1'b1, IDX_PAGE, 8'(p), 4'h1, rdata);
            rd_chk("page value", IDX_PAGE, 32'h000000F0 | 32'(p));
            map_chk(1'b0, 16'h8123, 1'b0, 1'b0, 4'(p), 1'b0, p > 0 && p < 14);
            map_chk(1'b0, 16'hC010, 1'b0, 1'b0, 4'(p), 1'b0, 1'b0);
        end
        bus(1'b1, IDX_PAGE, 8'h03, 4'h0, rdata);
        rd_chk("page no lane", IDX_PAGE, 32'h000000FF);
        i_call_page <= 8'h05;
        i_call_page_wr <= 1'b1;
        @(posedge i_clock);
        i_call_page_wr <= 1'b0;
        @(posedge i_clock);
        rd_chk("far call page", IDX_PAGE, 32'h000000F5);
        bus(1'b1, IDX_PAGE, 8'h0E, 4'h1, rdata);
    endtask
    task automatic sc_debug();
        i_dbg_active <= 1'b1;
        map_chk(1'b1, 16'hFF10, 1'b0, 1'b1, 4'hE, 1'b1, 1'b0);
        map_chk(1'b1, 16'hFF10, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
        map_chk(1'b0, 16'hFF20, 1'b1, 1'b1, 4'hE, 1'b1, 1'b0);
        map_chk(1'b1, 16'hBF20, 1'b0, 1'b1, 4'hE, 1'b0, 1'b0);
        bus(1'b1, IDX_PAGE, 8'h0F, 4'h1, rdata);
        map_chk(1'b1, 16'hBF20, 1'b0, 1'b1, 4'hF, 1'b1, 1'b0);
        i_dbg_active <= 1'b0;
        map_chk(1'b1, 16'hFF10, 1'b0, 1'b1, 4'hF, 1'b0, 1'b0);
        bus(1'b1, IDX_PAGE, 8'h0E, 4'h1, rdata);
    endtask
    task automatic sc_dbg_page();
        bus(1'b1, IDX_DBGPAGE, 8'h0C, 4'h1, rdata);
        bus(1'b0, IDX_DBGPAGE, 8'h00, 4'h1, rdata);
        check("debug page", 32'h0000000C, rdata & 32'h0000000F);
        i_dbg_page_enable <= 1'b1;
        map_chk(1'b1, 16'h8010, 1'b0, 1'b0, 4'hC, 1'b0, 1'b0);
        map_chk(1'b0, 16'h8010, 1'b1, 1'b0, 4'hC, 1'b0, 1'b0);
        map_chk(1'b0, 16'h8010, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
        i_dbg_page_enable <= 1'b0;
        map_chk(1'b1, 16'h8010, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
    endtask
    task automatic sc_stop();
        i_stop <= 1'b1;
        u_cpu_master.issue(16'h0900, 1'b0, 1'b0, 0);
        @(posedge i_clock);
        check("stop valid", 32'h0, {31'h0, o_cpu_map.valid});
        i_stop <= 1'b0;
        repeat (2) @(posedge i_clock);
        map_chk(1'b0, 16'h0900, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset(1'b1);
        sc_reset_values();
        sc_mode();
        do_reset(1'b1);
        sc_mapctl();
        sc_paging();
        sc_debug();
        sc_dbg_page();
        sc_stop();
        give_verdict();
    end
endmodule // test_memory_map_mode_control
